/* File: include/pin_mux_cfg.svh */
// How it works
// - clock output pin carries the buffered clock picked by the select register
// - software routes the input clock straight to the core or to the pll
// - when bus drive bit is zero, idle bus tri-states address and control
// - shared pins carry address bits 0 to 5, port a lines 8 to 13
// - in port mode each of the six pins is input or output on its own
// - after reset the shared pins are in address bus function
// - clearing pull-up register bit n turns off line n pull-up
// - mode pin high: external clock on osc out pin; low: crystal
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

`define ADDR_W        8
`define DATA_W        16
// register offsets
`define OFS_CLK_SEL   8'h00
`define OFS_CLK_ROUTE 8'h04
`define OFS_BUS_CTRL  8'h08
`define OFS_PA_FUNC   8'h0c
`define OFS_PA_DIR    8'h10
`define OFS_PA_DOUT   8'h14
`define OFS_PA_DIN    8'h18
`define OFS_PA_PUR    8'h1c
`define OFS_STATUS    8'h20
// field positions
`define PA_LO         8
`define PA_HI         13
`define BUS_DRV_POS   0
`define ROUTE_PLL_POS 0
`define STAT_MODE_POS 0
`define STAT_BUS_POS  1
// reset values
`define CLK_SEL_RST   3'h0
`define ROUTE_RST     1'b0
`define BUS_DRV_RST   1'b0
`define PA_FUNC_RST   6'h00
`define PA_DIR_RST    6'h00
`define PA_DOUT_RST   6'h00
`define PA_PUR_RST    6'h3f
`define MODE_RST      1'b1
`define CTRL_IDLE     3'h7

`endif

/* File: include/pin_mux_pkg.sv */
package pin_mux_pkg;
   // clock output source codes
   typedef enum logic [2:0] {
      SRC_OFF    = 3'b000,
      SRC_MASTER = 3'b001,
      SRC_PERIPH = 3'b010,
      SRC_OSC    = 3'b011,
      SRC_PRE    = 3'b100,
      SRC_POST   = 3'b101,
      SRC_TEST0  = 3'b110,
      SRC_TEST1  = 3'b111
   } clk_src_sel_t;

   // candidate clocks for the clock output pin
   typedef struct packed {
      logic       master;
      logic       periph;
      logic       osc;
      logic       prescale;
      logic       postscale;
      logic [1:0] test;
   } clk_sources_t;

   // request from the external memory interface
   typedef struct packed {
      logic       active;
      logic [5:0] addr;
      logic [2:0] ctrl;
   } ext_bus_t;

   // six shared pads: value, enable, pull-up
   typedef struct packed {
      logic [5:0] o;
      logic [5:0] oe;
      logic [5:0] pu;
   } pad_group_t;
endpackage : pin_mux_pkg

/* File: logic/clock_out_select.sv */
`timescale 1ns/10ps
`include "pin_mux_cfg.svh"
module clock_out_select
   import pin_mux_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire clk_src_sel_t sel,
   input  wire clk_sources_t src,
   output logic              pin_o,
   output logic              pin_oe
);
   logic oe_d;
   logic oe_q;

   // source pick, combinational so the clock is not resampled
   always_comb begin
      case (sel)
         SRC_MASTER: pin_o = src.master;
         SRC_PERIPH: pin_o = src.periph;
         SRC_OSC:    pin_o = src.osc;
         SRC_PRE:    pin_o = src.prescale;
         SRC_POST:   pin_o = src.postscale;
         SRC_TEST0:  pin_o = src.test[0];
         SRC_TEST1:  pin_o = src.test[1];
         default:    pin_o = 1'b0;
      endcase
      oe_d = (sel != SRC_OFF);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end
   assign pin_oe = oe_q;

   property p_off_quiet;
      @(posedge mclk) disable iff (rst) (sel == SRC_OFF) |-> pin_o == 1'b0 ##1 !pin_oe;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("clock out driven while off");

   property p_master_path;
      @(posedge mclk) disable iff (rst)
         (sel == SRC_MASTER) ##1 (sel == SRC_MASTER) |-> pin_oe && pin_o == src.master;
   endproperty
   a_master_path: assert property (p_master_path) else $error("master clock not on pin");
endmodule : clock_out_select

/* File: logic/clock_out_and_address_pin_mux.sv */
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "pin_mux_cfg.svh"
module clock_out_and_address_pin_mux
   import pin_mux_pkg::*;
(
   input  wire logic [`ADDR_W-1:0] addr,
   input  wire logic [`DATA_W-1:0] wdata,
   input  wire logic               wr_en,
   input  wire logic               rd_en,
   output logic      [`DATA_W-1:0] rdata,
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire clk_sources_t       clk_src,
   input  wire logic               clock_input_mode_pin,
   input  wire logic               osc_in_pin,
   input  wire logic               osc_out_pin_i,
   output logic                    osc_out_pin_o,
   output logic                    osc_out_pin_oe,
   output logic                    core_clk,
   output logic                    pll_ref_clk,
   input  wire ext_bus_t           ext_bus,
   input  wire logic [5:0]         addr_pin_i,
   output pad_group_t              addr_pads,
   output logic      [2:0]         ctrl_pin_o,
   output logic      [2:0]         ctrl_pin_oe,
   output logic                    clock_out_pin_o,
   output logic                    clock_out_pin_oe
);
   // software visible state
   clk_src_sel_t       sel_q,   sel_d;
   logic               route_q, route_d;
   logic               drv_q,   drv_d;
   logic [5:0]         func_q,  func_d;
   logic [5:0]         dir_q,   dir_d;
   logic [5:0]         dout_q,  dout_d;
   logic [5:0]         pur_q,   pur_d;
   logic [`DATA_W-1:0] rdata_q, rdata_d;
   // pad state
   logic [5:0]         pad_o_q,  pad_o_d;
   logic [5:0]         pad_oe_q, pad_oe_d;
   logic [2:0]         ctl_o_q,  ctl_o_d;
   logic [2:0]         ctl_oe_q, ctl_oe_d;
   logic               mode_q;
   logic               input_clk;

   // true when the address matches a given offset
   function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                input logic [`ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // register writes
   always_comb begin
      sel_d   = sel_q;
      route_d = route_q;
      drv_d   = drv_q;
      func_d  = func_q;
      dir_d   = dir_q;
      dout_d  = dout_q;
      pur_d   = pur_q;
      if (wr_en) begin
         if (hit(addr, `OFS_CLK_SEL)) begin
            sel_d = clk_src_sel_t'(wdata[2:0]);
         end
         if (hit(addr, `OFS_CLK_ROUTE)) begin
            route_d = wdata[`ROUTE_PLL_POS];
         end
         if (hit(addr, `OFS_BUS_CTRL)) begin
            drv_d = wdata[`BUS_DRV_POS];
         end
         if (hit(addr, `OFS_PA_FUNC)) begin
            func_d = wdata[`PA_HI:`PA_LO];
         end
         if (hit(addr, `OFS_PA_DIR)) begin
            dir_d = wdata[`PA_HI:`PA_LO];
         end
         if (hit(addr, `OFS_PA_DOUT)) begin
            dout_d = wdata[`PA_HI:`PA_LO];
         end
         if (hit(addr, `OFS_PA_PUR)) begin
            pur_d = wdata[`PA_HI:`PA_LO];
         end
      end
   end

   // read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_d = '0;
      if (rd_en) begin
         case (addr)
            `OFS_CLK_SEL:   rdata_d[2:0] = sel_q;
            `OFS_CLK_ROUTE: rdata_d[`ROUTE_PLL_POS] = route_q;
            `OFS_BUS_CTRL:  rdata_d[`BUS_DRV_POS] = drv_q;
            `OFS_PA_FUNC:   rdata_d[`PA_HI:`PA_LO] = func_q;
            `OFS_PA_DIR:    rdata_d[`PA_HI:`PA_LO] = dir_q;
            `OFS_PA_DOUT:   rdata_d[`PA_HI:`PA_LO] = dout_q;
            `OFS_PA_DIN:    rdata_d[`PA_HI:`PA_LO] = addr_pin_i;
            `OFS_PA_PUR:    rdata_d[`PA_HI:`PA_LO] = pur_q;
            `OFS_STATUS: begin
               rdata_d[`STAT_MODE_POS] = mode_q;
               rdata_d[`STAT_BUS_POS]  = ext_bus.active;
            end
            default:        rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel_q   <= clk_src_sel_t'(`CLK_SEL_RST);
         route_q <= `ROUTE_RST;
         drv_q   <= `BUS_DRV_RST;
         func_q  <= `PA_FUNC_RST;
         dir_q   <= `PA_DIR_RST;
         dout_q  <= `PA_DOUT_RST;
         pur_q   <= `PA_PUR_RST;
         rdata_q <= '0;
      end else begin
         sel_q   <= sel_d;
         route_q <= route_d;
         drv_q   <= drv_d;
         func_q  <= func_d;
         dir_q   <= dir_d;
         dout_q  <= dout_d;
         pur_q   <= pur_d;
         rdata_q <= rdata_d;
      end
   end
   assign rdata = rdata_q;

   // per pin function: address bus or port line
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_pad
         always_comb begin
            if (func_q[g]) begin
               pad_o_d[g]  = dout_q[g];
               pad_oe_d[g] = dir_q[g];
            end else begin
               pad_o_d[g]  = ext_bus.addr[g];
               pad_oe_d[g] = ext_bus.active | drv_q;
            end
         end
      end
   endgenerate

   // control strobes follow the same idle policy
   always_comb begin
      ctl_o_d  = ext_bus.active ? ext_bus.ctrl : `CTRL_IDLE;
      ctl_oe_d = {3{ext_bus.active | drv_q}};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pad_o_q  <= '0;
         pad_oe_q <= '0;
         ctl_o_q  <= `CTRL_IDLE;
         ctl_oe_q <= '0;
         mode_q   <= `MODE_RST;
      end else begin
         pad_o_q  <= pad_o_d;
         pad_oe_q <= pad_oe_d;
         ctl_o_q  <= ctl_o_d;
         ctl_oe_q <= ctl_oe_d;
         mode_q   <= clock_input_mode_pin;
      end
   end

   always_comb begin
      addr_pads.o  = pad_o_q;
      addr_pads.oe = pad_oe_q;
      addr_pads.pu = pur_q;
   end
   assign ctrl_pin_o  = ctl_o_q;
   assign ctrl_pin_oe = ctl_oe_q;

   // oscillator pin role and input clock
   always_comb begin
      osc_out_pin_o  = ~osc_in_pin;
      osc_out_pin_oe = ~mode_q;
      input_clk      = mode_q ? osc_out_pin_i : osc_in_pin;
   end

   always_comb begin
      core_clk    = route_q ? 1'b0 : input_clk;
      pll_ref_clk = route_q ? input_clk : 1'b0;
   end

   clock_out_select u_clock_out (
      .mclk   (mclk),
      .rst    (rst),
      .sel    (sel_q),
      .src    (clk_src),
      .pin_o  (clock_out_pin_o),
      .pin_oe (clock_out_pin_oe)
   );

   property p_reset_quiet;
      @(posedge mclk) $fell(rst) |->
         addr_pads.oe == 6'h00 && !clock_out_pin_oe && addr_pads.pu == 6'h3f;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("pads active after reset");

   property p_reset_func;
      @(posedge mclk) $fell(rst) |-> func_q == 6'h00 ##1 (wr_en || func_q == 6'h00);
   endproperty
   a_reset_func: assert property (p_reset_func) else $error("port mode after reset");

   property p_idle_tristate;
      @(posedge mclk) disable iff (rst)
         (func_q == 6'h00 && !drv_q && !ext_bus.active) |=> addr_pads.oe == 6'h00
            && ctrl_pin_oe == 3'h0;
   endproperty
   a_idle_tristate: assert property (p_idle_tristate) else $error("idle bus driven");

   property p_drive_hold;
      @(posedge mclk) disable iff (rst)
         (func_q == 6'h00 && drv_q) |=> addr_pads.oe == 6'h3f && ctrl_pin_oe == 3'h7;
   endproperty
   a_drive_hold: assert property (p_drive_hold) else $error("bus not held");

   property p_addr_out;
      @(posedge mclk) disable iff (rst)
         (func_q == 6'h00 && ext_bus.active) |=>
            addr_pads.o == $past(ext_bus.addr) && addr_pads.oe == 6'h3f;
   endproperty
   a_addr_out: assert property (p_addr_out) else $error("address bits not on pins");

   property p_port_mode;
      @(posedge mclk) disable iff (rst)
         (func_q == 6'h3f) |=> addr_pads.oe == $past(dir_q) && addr_pads.o == $past(dout_q);
   endproperty
   a_port_mode: assert property (p_port_mode) else $error("port line wrong");

   property p_pullup_write;
      @(posedge mclk) disable iff (rst)
         (wr_en && addr == `OFS_PA_PUR) |=> addr_pads.pu == $past(wdata[`PA_HI:`PA_LO]);
   endproperty
   a_pullup_write: assert property (p_pullup_write) else $error("pull-up not updated");

   property p_route;
      @(posedge mclk) disable iff (rst)
         (wr_en && addr == `OFS_CLK_ROUTE && wdata[0]) |=> core_clk == 1'b0
            && pll_ref_clk == input_clk;
   endproperty
   a_route: assert property (p_route) else $error("pll route wrong");

   property p_mode_pin;
      @(posedge mclk) disable iff (rst)
         clock_input_mode_pin |=> !osc_out_pin_oe && input_clk == osc_out_pin_i;
   endproperty
   a_mode_pin: assert property (p_mode_pin) else $error("osc pin role wrong");

   property p_sel_off;
      @(posedge mclk) disable iff (rst)
         (wr_en && addr == `OFS_CLK_SEL && wdata[2:0] == 3'h0) ##1 !wr_en |=>
            !clock_out_pin_oe;
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("clock out not disabled");
endmodule : clock_out_and_address_pin_mux

/* File: testbench/ext_mem_model.sv */
`timescale 1ns/10ps
module ext_mem_model
   import pin_mux_pkg::*;
(
   input  wire logic       mclk,
   input  wire pad_group_t pads,
   input  wire logic [5:0] drv_v,
   input  wire logic [5:0] drv_oe,
   output logic      [5:0] lvl
);
   logic [5:0] last_q = 6'h00;

   // released pins float only with no far side drive and no pull-up
   // wire level per pin: device, far side, pull-up, else floats inverted
   always_comb begin
      for (int g = 0; g < 6; g++) begin
         if (pads.oe[g])
            lvl[g] = pads.o[g];
         else if (drv_oe[g])
            lvl[g] = drv_v[g];
         else if (pads.pu[g])
            lvl[g] = 1'b1;
         else
            lvl[g] = ~last_q[g];
      end
   end

   // last level, so a floating pin never repeats it
   always @(posedge mclk) begin
      last_q <= lvl;
   end
endmodule : ext_mem_model

/* File: testbench/clock_out_and_address_pin_mux_test.sv */
`timescale 1ns/10ps
`include "pin_mux_cfg.svh"
module clock_out_and_address_pin_mux_test;
   import pin_mux_pkg::*;
   logic [`ADDR_W-1:0] addr;
   logic [`DATA_W-1:0] wdata, rdata;
   logic               wr_en, rd_en, mclk, rst, mode, osc_in, osc_out_i;
   logic               osc_out_o, osc_out_oe, core_clk, pll_ref, clk_out, clk_out_oe;
   clk_sources_t       clk_src;
   ext_bus_t           ext_bus;
   pad_group_t         pads;
   logic [2:0]         ctrl_o, ctrl_oe;
   logic [5:0]         lvl, drv_v, drv_oe, a, dir, dout;
   logic [15:0]        exp_q[$];
   logic               rd_seen = 1'b0;
   logic               c;
   integer             seed, n_fail = 0, n_compared = 0, cyc = 0;

   clock_out_and_address_pin_mux uut (.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .mclk(mclk), .rst(rst), .clk_src(clk_src), .clock_input_mode_pin(mode),
      .osc_in_pin(osc_in), .osc_out_pin_i(osc_out_i), .osc_out_pin_o(osc_out_o),
      .osc_out_pin_oe(osc_out_oe), .core_clk(core_clk), .pll_ref_clk(pll_ref),
      .ext_bus(ext_bus), .addr_pin_i(lvl), .addr_pads(pads), .ctrl_pin_o(ctrl_o),
      .ctrl_pin_oe(ctrl_oe), .clock_out_pin_o(clk_out), .clock_out_pin_oe(clk_out_oe));
   ext_mem_model mem (.mclk(mclk), .pads(pads), .drv_v(drv_v), .drv_oe(drv_oe), .lvl(lvl));

   // clock and hang limit
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] e);
      n_compared++;
      if (got !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h expected %h", $time, got, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
      @(posedge mclk);
      addr  <= ofs;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ofs, input logic [15:0] e);
      @(posedge mclk);
      addr  <= ofs;
      rd_en <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      rd_en <= 1'b0;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : settle

   // read data watcher: oldest note against the cycle after the strobe
   always @(negedge mclk) begin
      if (rd_seen)
         chk(rdata, exp_q.pop_front());
      rd_seen = rd_en;
   end

   task conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   initial begin
      seed = 63;
      {mclk, rst, addr, wdata, wr_en, rd_en, clk_src} = {2'b01, 33'h0};
      {mode, osc_in, osc_out_i, ext_bus, drv_v, drv_oe} = {1'b1, 24'h0};
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      chk({pads.oe, ctrl_oe, clk_out_oe, osc_out_oe}, 16'h0);
      chk(pads.pu, 16'h3f);
      @(posedge mclk);
      rst <= 1'b0;
      rd(`OFS_PA_FUNC, 16'h0000);
      rd(8'h40, 16'h0000);
      repeat (4) begin
         @(posedge mclk);
         a = 6'($random(seed));
         ext_bus <= {1'b1, a, 3'h2};
         settle(1);
         chk(lvl, a);
         chk({ctrl_oe, ctrl_o}, {3'h7, 3'h2});
      end
      rd(`OFS_STATUS, 16'h0003);
      @(posedge mclk);
      ext_bus.active <= 1'b0;
      settle(1);
      chk({pads.oe, ctrl_oe, lvl}, 16'h3f);
      wr(`OFS_BUS_CTRL, 16'h0001);
      settle(1);
      chk({pads.oe, ctrl_oe, ctrl_o}, 16'hfff);
      rd(`OFS_BUS_CTRL, 16'h0001);
      wr(`OFS_PA_PUR, 16'h3e00);
      settle(1);
      chk(pads.pu, 16'h3e);
      rd(`OFS_PA_PUR, 16'h3e00);
      wr(`OFS_PA_FUNC, 16'h3f00);
      repeat (3) begin
         dir  = 6'($random(seed));
         dout = 6'($random(seed));
         wr(`OFS_PA_DIR, {2'b00, dir, 8'h00});
         wr(`OFS_PA_DOUT, {2'b00, dout, 8'h00});
         drv_oe <= ~dir;
         drv_v  <= 6'($random(seed));
         settle(1);
         a = (dout & dir) | (drv_v & ~dir);
         chk({pads.oe, lvl}, {4'h0, dir, a});
         rd(`OFS_PA_DIN, {2'b00, a, 8'h00});
         rd(`OFS_PA_DIR, {2'b00, dir, 8'h00});
         rd(`OFS_PA_DOUT, {2'b00, dout, 8'h00});
      end
      for (int s = 0; s < 8; s++) begin
         wr(`OFS_CLK_SEL, 16'(s));
         repeat (2) begin
            clk_src <= ~clk_src ^ 7'($random(seed));
            settle(1);
            c = (s == 0) ? 1'b0 : (s < 6) ? clk_src[7-s] : clk_src[s-6];
            chk({clk_out_oe, clk_out}, {14'h0, s != 0, c});
         end
         rd(`OFS_CLK_SEL, 16'(s));
      end
      for (int k = 0; k < 16; k++) begin
         wr(`OFS_CLK_ROUTE, 16'(k[0]));
         @(posedge mclk);
         {mode, osc_in, osc_out_i} <= {k[1], k[2], k[3]};
         settle(1);
         c = k[1] ? k[3] : k[2];
         chk({osc_out_oe, core_clk, pll_ref}, {~k[1], ~k[0] & c, k[0] & c});
         if (!k[1])
            chk(osc_out_o, {15'h0, ~k[2]});
         rd(`OFS_STATUS, 16'(k[1]));
         rd(`OFS_CLK_ROUTE, 16'(k[0]));
      end
      settle(2);
      conclude();
   end
endmodule : clock_out_and_address_pin_mux_test
